// ==== hw/etc_map.vh ====
// Register map and timing constants for the exposure trigger control block.
// Assumes a 100 MHz clock and a 32-bit AHB-Lite register port.
`ifndef ETC_MAP_VH
`define ETC_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define ETC_OFS_CTRL      8'h00
`define ETC_OFS_EXPOSURE  8'h04
`define ETC_OFS_PERIOD    8'h08
`define ETC_OFS_HEIGHT    8'h0C
`define ETC_OFS_LINETIME  8'h10
`define ETC_OFS_COMMAND   8'h14
`define ETC_OFS_STATUS    8'h18

// ---------------------------------------------------------------
// Control register fields.
// ---------------------------------------------------------------
`define ETC_CTRL_EXTSYNC  0
`define ETC_CTRL_SRC_LO   1
`define ETC_CTRL_SRC_HI   2
`define ETC_CTRL_FALLING  3
`define ETC_CTRL_WIDTH    4

// Trigger origin codes.
`define ETC_SRC_SOFT      2'h0
`define ETC_SRC_LINK      2'h1
`define ETC_SRC_LINE      2'h2

// Command register bits (write one to act).
`define ETC_CMD_START     0
`define ETC_CMD_STOP      1
`define ETC_CMD_SOFTTRIG  2

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define ETC_RST_CTRL      5'h00
`define ETC_RST_EXPOSURE  32'h0000_03E8
`define ETC_RST_PERIOD    32'h0000_2710
`define ETC_RST_HEIGHT    16'h1774
`define ETC_RST_LINETIME  16'h0064

// ---------------------------------------------------------------
// Timing: one microsecond in clock cycles, and exposure limits.
// ---------------------------------------------------------------
`define ETC_CLK_MHZ       100
`define ETC_US_CYCLES     (`ETC_CLK_MHZ)
`define ETC_US_LAST       7'h63
`define ETC_EXP_MIN_US    32'h0000_0001
`define ETC_EXP_MAX_US    32'h0393_8700

`endif

// ==== hw/etc_edge_sync.v ====
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
`include "etc_map.vh"

module etc_edge_sync (
  input  wire clk,
  input  wire rst_b,
  input  wire pin,
  output reg  level,
  output reg  rise,
  output reg  fall
);

  reg meta_r; // First stage, read only by the second stage.
  reg sync_r; // Second stage, safe to read.

  // ---------------------------------------------------------------
  // Synchroniser and edge detection.
  // ---------------------------------------------------------------
  // The edge detector compares the second and a third stage so that
  // the metastable first stage never reaches any logic.
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      level  <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      level  <= sync_r;
      rise   <= sync_r & ~level;
      fall   <= ~sync_r & level;
    end
  end

endmodule

// ==== hw/etc_top.v ====
// Exposure trigger control: picks a trigger origin, times exposure
// and paces sensor readout; registers reached over AHB-Lite.
// Assumes one 100 MHz clock and asynchronous trigger pins.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "etc_map.vh"

module etc_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        external_line_input,
  input  wire        link_trigger_input,
  output reg         exposure_window,
  output reg         readout_active,
  output reg         line_strobe
);

  // ---------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------
  reg  [4:0]  ctrl_r;       // Sync enable, origin, polarity, width mode.
  reg  [31:0] exposure_r;   // Exposure duration in microseconds.
  reg  [31:0] period_r;     // Free-run frame period in microseconds, less one.
  reg  [15:0] height_r;     // Image height in lines.
  reg  [15:0] linetime_r;   // Clock cycles per readout line.
  reg         running_r;    // Acquisition started and not stopped.
  reg         soft_trig_r;  // One-cycle software trigger pulse.
  reg  [31:0] ignored_r;    // Count of triggers dropped while busy.
  reg  [31:0] frames_r;     // Count of exposures started.
  reg         ph_wr_r;      // Data phase pending: write.
  reg         ph_rd_r;      // Data phase pending: read.
  reg  [7:0]  ph_addr_r;    // Latched byte offset.

  // ---------------------------------------------------------------
  // Exposure and readout state.
  // ---------------------------------------------------------------
  localparam [0:0] EXP_WAIT = 1'b0;
  localparam [0:0] EXP_BUSY = 1'b1;
  reg  [0:0]  exp_state_r;
  reg  [0:0]  exp_state_nxt;
  reg  [6:0]  us_cnt_r;     // Cycles within the current microsecond.
  reg  [31:0] exp_us_r;     // Microseconds of exposure left.
  reg  [31:0] fr_us_r;      // Microseconds to next free-run trigger.
  reg  [15:0] line_left_r;  // Readout lines still to go.
  reg  [15:0] line_cyc_r;   // Cycles left in the current line.

  wire line_lvl;
  wire line_rise;
  wire line_fall;
  wire link_lvl;
  wire link_rise;
  wire link_fall;

  // Both trigger inputs are asynchronous pins.
  etc_edge_sync u_line (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (external_line_input),
    .level (line_lvl),
    .rise  (line_rise),
    .fall  (line_fall)
  );

  etc_edge_sync u_link (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (link_trigger_input),
    .level (link_lvl),
    .rise  (link_rise),
    .fall  (link_fall)
  );

  // Clamp the programmed duration into its legal range.
  function [31:0] clamp_us;
    input [31:0] v;
    begin
      if (v < `ETC_EXP_MIN_US) begin
        clamp_us = `ETC_EXP_MIN_US;
      end else if (v > `ETC_EXP_MAX_US) begin
        clamp_us = `ETC_EXP_MAX_US;
      end else begin
        clamp_us = v;
      end
    end
  endfunction

  // Pick one edge pulse of the origin pin. Start and end edges both come
  // from here, so the two can never disagree on which pin is meant.
  function pick_edge;
    input       on_line;   // The line input is the origin.
    input       want_fall; // The falling edge is wanted.
    input [1:0] line_ev;   // Fall and rise pulses of the line input.
    input [1:0] link_ev;   // Fall and rise pulses of the link input.
    begin
      if (on_line) begin
        pick_edge = want_fall ? line_ev[1] : line_ev[0];
      end else begin
        pick_edge = want_fall ? link_ev[1] : link_ev[0];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Trigger selection.
  // ---------------------------------------------------------------
  wire       ext_sync  = ctrl_r[`ETC_CTRL_EXTSYNC];
  wire [1:0] src       = ctrl_r[`ETC_CTRL_SRC_HI:`ETC_CTRL_SRC_LO];
  wire       falling   = ctrl_r[`ETC_CTRL_FALLING];
  wire       ext_src   = (src == `ETC_SRC_LINK) || (src == `ETC_SRC_LINE);
  // Software origin always runs timed, whatever the width bit says.
  wire       width_md  = ctrl_r[`ETC_CTRL_WIDTH] & ext_sync & ext_src;
  wire       us_tick   = (us_cnt_r == `ETC_US_LAST);
  // The start edge follows the polarity and the end edge is its opposite.
  wire       pin_start = pick_edge(src == `ETC_SRC_LINE, falling,
                                   {line_fall, line_rise}, {link_fall, link_rise});
  wire       pin_end   = pick_edge(src == `ETC_SRC_LINE, ~falling,
                                   {line_fall, line_rise}, {link_fall, link_rise});
  reg        trig;

  // Pick the trigger that applies in the current mode.
  always @* begin
    if (!ext_sync) begin
      trig = running_r && us_tick && (fr_us_r == 32'h0000_0000);
    end else if (src == `ETC_SRC_SOFT) begin
      trig = soft_trig_r;
    end else if (ext_src) begin
      trig = pin_start;
    end else begin
      trig = 1'b0;
    end
  end

  wire timed_done = (exp_us_r == 32'h0000_0001) && us_tick;
  wire exp_end    = (exp_state_r == EXP_BUSY) && (width_md ? pin_end : timed_done);

  // Next exposure state.
  always @* begin
    case (exp_state_r)
      EXP_WAIT: exp_state_nxt = trig ? EXP_BUSY : EXP_WAIT;
      EXP_BUSY: exp_state_nxt = exp_end ? EXP_WAIT : EXP_BUSY;
      default:  exp_state_nxt = EXP_WAIT;
    endcase
  end

  // ---------------------------------------------------------------
  // Exposure timing, free-run pacing and readout.
  // ---------------------------------------------------------------
  // Readout is independent of exposure, so a new exposure may start
  // while the last frame still reads out; the source keeps it from
  // ending before readout completes.
  always @(posedge clk) begin
    if (!rst_b) begin
      exp_state_r     <= EXP_WAIT;
      us_cnt_r        <= 7'h00;
      exp_us_r        <= 32'h0000_0000;
      fr_us_r         <= 32'h0000_0000;
      line_left_r     <= 16'h0000;
      line_cyc_r      <= 16'h0000;
      exposure_window <= 1'b0;
      readout_active  <= 1'b0;
      line_strobe     <= 1'b0;
      ignored_r       <= 32'h0000_0000;
      frames_r        <= 32'h0000_0000;
    end else begin
      exp_state_r     <= exp_state_nxt;
      exposure_window <= (exp_state_nxt == EXP_BUSY);
      // Microsecond prescaler restarts with each exposure.
      if (trig && exp_state_r == EXP_WAIT) begin
        us_cnt_r <= 7'h00;
      end else if (us_tick) begin
        us_cnt_r <= 7'h00;
      end else begin
        us_cnt_r <= us_cnt_r + 7'h01;
      end
      if (trig && exp_state_r == EXP_WAIT) begin
        exp_us_r <= clamp_us(exposure_r);
        frames_r <= frames_r + 32'h0000_0001;
      end else if (exp_state_r == EXP_BUSY && us_tick && exp_us_r != 32'h0000_0000) begin
        exp_us_r <= exp_us_r - 32'h0000_0001;
      end
      if (trig && exp_state_r == EXP_BUSY) begin
        ignored_r <= ignored_r + 32'h0000_0001;
      end
      // Free-run period counter, reloaded at each internal trigger.
      if (!running_r || ext_sync) begin
        fr_us_r <= 32'h0000_0000;
      end else if (us_tick) begin
        fr_us_r <= (fr_us_r == 32'h0000_0000) ? period_r : fr_us_r - 32'h0000_0001;
      end
      // Readout starts right after exposure ends, one line at a time.
      line_strobe <= 1'b0;
      if (exp_end) begin
        line_left_r    <= height_r;
        line_cyc_r     <= linetime_r;
        readout_active <= (height_r != 16'h0000);
      end else if (readout_active) begin
        if (line_cyc_r <= 16'h0001) begin
          line_strobe <= 1'b1;
          line_cyc_r  <= linetime_r;
          line_left_r <= line_left_r - 16'h0001;
          if (line_left_r == 16'h0001) begin
            readout_active <= 1'b0;
          end
        end else begin
          line_cyc_r <= line_cyc_r - 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY.
  // ---------------------------------------------------------------
  wire addr_ok = hsel && hready && htrans[1];

  // Address phase latch, data phase writes and commands.
  always @(posedge clk) begin
    if (!rst_b) begin
      ph_wr_r     <= 1'b0;
      ph_rd_r     <= 1'b0;
      ph_addr_r   <= 8'h00;
      ctrl_r      <= `ETC_RST_CTRL;
      exposure_r  <= `ETC_RST_EXPOSURE;
      period_r    <= `ETC_RST_PERIOD;
      height_r    <= `ETC_RST_HEIGHT;
      linetime_r  <= `ETC_RST_LINETIME;
      running_r   <= 1'b0;
      soft_trig_r <= 1'b0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
    end else begin
      ph_wr_r     <= addr_ok & hwrite;
      ph_rd_r     <= addr_ok & ~hwrite;
      ph_addr_r   <= haddr[7:0];
      soft_trig_r <= 1'b0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      if (ph_wr_r) begin
        case (ph_addr_r)
          `ETC_OFS_CTRL:     ctrl_r     <= hwdata[4:0];
          `ETC_OFS_EXPOSURE: exposure_r <= hwdata;
          `ETC_OFS_PERIOD:   period_r   <= hwdata;
          `ETC_OFS_HEIGHT:   height_r   <= hwdata[15:0];
          `ETC_OFS_LINETIME: linetime_r <= hwdata[15:0];
          `ETC_OFS_COMMAND: begin
            if (hwdata[`ETC_CMD_START]) begin
              running_r <= 1'b1;
            end
            if (hwdata[`ETC_CMD_STOP]) begin
              running_r <= 1'b0;
            end
            soft_trig_r <= hwdata[`ETC_CMD_SOFTTRIG];
          end
          default: ;
        endcase
      end
      // Reads are answered in the cycle after the address phase, so
      // hrdata is a register rather than a mux on the bus.
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          `ETC_OFS_CTRL:     hrdata <= {27'h0000000, ctrl_r};
          `ETC_OFS_EXPOSURE: hrdata <= exposure_r;
          `ETC_OFS_PERIOD:   hrdata <= period_r;
          `ETC_OFS_HEIGHT:   hrdata <= {16'h0000, height_r};
          `ETC_OFS_LINETIME: hrdata <= {16'h0000, linetime_r};
          `ETC_OFS_STATUS:   hrdata <= {frames_r[13:0], ignored_r[13:0], line_lvl ^ link_lvl,
                                        running_r, readout_active, exposure_window};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ==== testbench/etc_monitor.sv ====
// Port checker for the exposure trigger control block.
// Assumes mode and exposure registers change only while no exposure runs.
`timescale 1ns/100ps
`include "etc_map.vh"

module etc_monitor (
  input wire        clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        external_line_input,
  input wire        link_trigger_input,
  input wire        exposure_window,
  input wire        readout_active,
  input wire        line_strobe
);
  reg  [31:0] ctrl_r;   // Shadow of the control register.
  reg  [31:0] exp_r;    // Shadow of the exposure register.
  reg         wpend_r;  // A write data phase is under way.
  reg  [7:0]  wadr_r;   // Offset of that write.
  reg  [39:0] hi_cnt_r; // Cycles the window has stood high.
  wire        ext_mode; // A pin is the trigger origin.
  wire        sel_pin;  // The pin that is the origin.
  wire        timed;    // Exposure length comes from the register.
  wire [39:0] exp_cyc;  // Expected timed length; wide, as the top value overflows 32 bits.

  assign ext_mode = ctrl_r[0] & (ctrl_r[2:1] != 2'h0);
  assign sel_pin  = (ctrl_r[2:1] == `ETC_SRC_LINE) ? external_line_input : link_trigger_input;
  assign timed    = !(ext_mode & ctrl_r[4]);
  assign exp_cyc  = ((exp_r == 32'h0) ? 32'h1 : (exp_r > `ETC_EXP_MAX_US) ? `ETC_EXP_MAX_US : exp_r)
                    * `ETC_US_CYCLES;

  // Follow bus writes so that the properties know the current mode.
  always @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r  <= {27'h0000000, `ETC_RST_CTRL};
      exp_r   <= `ETC_RST_EXPOSURE;
      wpend_r <= 1'b0;
    end else begin
      wpend_r <= hsel & hready & htrans[1] & hwrite;
      if (wpend_r && wadr_r == `ETC_OFS_CTRL) begin
        ctrl_r <= hwdata;
      end
      if (wpend_r && wadr_r == `ETC_OFS_EXPOSURE) begin
        exp_r <= hwdata;
      end
    end
  end

  // Address of the pending write and length of the current exposure.
  always @(posedge clk) begin
    wadr_r   <= haddr[7:0];
    hi_cnt_r <= (!rst_b || !exposure_window) ? 40'h0 : hi_cnt_r + 40'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Selected edge on the origin pin while waiting, and the ending edge.
  sequence s_start_edge;
    ext_mode && !exposure_window && (ctrl_r[3] ? $fell(sel_pin) : $rose(sel_pin));
  endsequence
  sequence s_stop_edge;
    ext_mode && !timed && exposure_window && (ctrl_r[3] ? $rose(sel_pin) : $fell(sel_pin));
  endsequence

  AST_TRIG_START: assert property (s_start_edge |-> ##[2:7] exposure_window)
    else $error("selected trigger edge did not open the window");
  AST_WIDTH_END: assert property (s_stop_edge |-> ##[2:7] !exposure_window)
    else $error("width mode window did not close on trigger");
  AST_TIMED_LEN: assert property ($fell(exposure_window) && timed |-> hi_cnt_r == exp_cyc)
    else $error("timed exposure length wrong");
  AST_READOUT: assert property ($fell(exposure_window) |-> readout_active)
    else $error("readout did not follow exposure");
  AST_STROBE_IN: assert property (line_strobe |-> readout_active || $past(readout_active))
    else $error("line strobe outside readout");
  AST_STROBE_PULSE: assert property (line_strobe |=> !line_strobe)
    else $error("line strobe longer than one cycle");
  AST_READY: assert property (hreadyout == 1'b1)
    else $error("hreadyout dropped");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("hresp not okay");
endmodule

bind etc_top etc_monitor u_mon (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .external_line_input, .link_trigger_input, .exposure_window, .readout_active,
  .line_strobe);

// ==== testbench/etc_trig_src.sv ====
// Trigger source model driving the line and link trigger pins.
// Assumes one bench process at a time calls its tasks.
`timescale 1ns/100ps

module etc_trig_src (
  input  wire clk,
  output reg  line_pin,
  output reg  link_pin
);
  // Both pins rest low until told otherwise.
  initial begin
    line_pin = 1'b0;
    link_pin = 1'b0;
  end

  // Rest both pins at the idle level of the chosen polarity.
  task idle(input reg lvl);
    begin
      @(posedge clk);
      line_pin <= lvl;
      link_pin <= lvl;
    end
  endtask

  // One active pulse on one pin; callers space pulses so that no exposure
  // ends while readout is still busy, though a new one may start then.
  task pulse(input reg on_link, input reg lvl, input integer cyc);
    integer i;
    begin
      @(posedge clk);
      if (on_link) link_pin <= !lvl;
      else line_pin <= !lvl;
      for (i = 0; i < cyc; i = i + 1) @(posedge clk);
      if (on_link) link_pin <= lvl;
      else line_pin <= lvl;
    end
  endtask
endmodule

// ==== testbench/etc_top_tb.sv ====
// Self-checking bench for the exposure trigger control block.
// Assumes the trigger source model and the bound port checker.
`timescale 1ns/100ps
`include "etc_map.vh"

module etc_top_tb;
  reg         clk;
  reg         rst_b;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        external_line_input;
  wire        link_trigger_input;
  wire        exposure_window;
  wire        readout_active;
  wire        line_strobe;
  reg  [31:0] rd;           // Last read data.
  integer     num_errors;
  integer     total_checks;
  integer     len;          // Cycles the window stood high.
  integer     gap;          // Cycles it then stood low.

  initial clk = 1'b0;
  always #5 clk = ~clk;

  etc_top DUT (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .external_line_input, .link_trigger_input, .exposure_window,
    .readout_active, .line_strobe);
  etc_trig_src u_src (.clk, .line_pin(external_line_input), .link_pin(link_trigger_input));

  task final_report;
    begin
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // One clock of a bounded wait; running out ends the run.
  task step(inout integer n);
    begin
      n = n + 1;
      if (n > 4000) begin
        num_errors = num_errors + 1;
        final_report;
      end else begin
        @(posedge clk);
      end
    end
  endtask

  // Single AHB-Lite word transfer; read data land in rd.
  task bus(input reg w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) step(n);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) step(n);
      rd = hrdata;
    end
  endtask

  task lowc(output integer l);
    integer n;
    begin
      n = 0;
      l = 0;
      while (exposure_window !== 1'b1) begin
        l = l + 1;
        step(n);
      end
    end
  endtask

  // Wait for the next exposure and measure how long it stands.
  task expo(output integer l);
    integer n;
    begin
      n = 0;
      lowc(l);
      l = 0;
      while (exposure_window === 1'b1) begin
        l = l + 1;
        step(n);
      end
    end
  endtask

  task t_regs;
    begin
      bus(0, `ETC_OFS_EXPOSURE, 0);
      check("exposure_rst", rd, `ETC_RST_EXPOSURE);
      bus(0, `ETC_OFS_PERIOD, 0);
      check("period_rst", rd, `ETC_RST_PERIOD);
      bus(0, `ETC_OFS_HEIGHT, 0);
      check("height_rst", rd, {16'h0000, `ETC_RST_HEIGHT});
      bus(1, 32'h0000_001C, 32'hFFFF_FFFF);
      bus(0, 32'h0000_001C, 0);
      check("unmapped", rd, 32'h0000_0000);
    end
  endtask

  // Timed line trigger, a second edge mid-exposure, then line readout.
  task t_timed;
    integer i;
    integer c;
    begin
      bus(1, `ETC_OFS_HEIGHT, 3);
      bus(1, `ETC_OFS_LINETIME, 4);
      bus(1, `ETC_OFS_EXPOSURE, 2);
      bus(1, `ETC_OFS_CTRL, 32'h5);
      fork
        begin
          u_src.pulse(0, 0, 20);
          repeat (60) @(posedge clk);
          u_src.pulse(0, 0, 20);
        end
        expo(len);
      join
      check("timed_len", len, 200);
      check("readout_on", readout_active, 1);
      c = 0;
      for (i = 0; i < 40; i = i + 1) begin
        if (line_strobe === 1'b1) c = c + 1;
        @(posedge clk);
      end
      check("lines", c, 3);
      bus(0, `ETC_OFS_STATUS, 0);
      check("ignored", rd[17:4], 1);
    end
  endtask

  // Link origin, falling width mode, longer than the timed setting.
  task t_width;
    begin
      bus(1, `ETC_OFS_EXPOSURE, 1);
      bus(1, `ETC_OFS_CTRL, 32'h1B);
      u_src.idle(1);
      repeat (20) @(posedge clk);
      fork
        u_src.pulse(1, 1, 300);
        expo(len);
      join
      check("width_len", len, 300);
    end
  endtask

  // Line width pulses every 120 cycles; the second overlaps readout.
  task t_rate;
    begin
      bus(1, `ETC_OFS_LINETIME, 30);
      bus(1, `ETC_OFS_CTRL, 32'h15);
      u_src.idle(0);
      repeat (20) @(posedge clk);
      fork
        begin
          u_src.pulse(0, 0, 40);
          repeat (79) @(posedge clk);
          u_src.pulse(0, 0, 40);
        end
        begin
          expo(len);
          lowc(gap);
          check("trig_period", len + gap, 120);
          check("overlap", readout_active, 1);
          expo(gap);
        end
      join
      check("rise_len", len, 40);
      check("second_len", gap, 40);
    end
  endtask

  // Software origin with width bit set still uses the timed length.
  task t_soft;
    begin
      bus(1, `ETC_OFS_CTRL, 32'h11);
      fork
        bus(1, `ETC_OFS_COMMAND, 32'h4);
        expo(len);
      join
      check("soft_len", len, 100);
    end
  endtask

  // Free run: start, one period of four microseconds, stop.
  task t_free;
    integer i;
    integer c;
    begin
      bus(1, `ETC_OFS_CTRL, 32'h0);
      bus(1, `ETC_OFS_PERIOD, 3);
      bus(1, `ETC_OFS_COMMAND, 32'h1);
      expo(len);
      lowc(gap);
      check("free_period", len + gap, 400);
      bus(1, `ETC_OFS_COMMAND, 32'h2);
      repeat (300) @(posedge clk);
      c = 0;
      for (i = 0; i < 800; i = i + 1) begin
        if (exposure_window !== 1'b0) c = c + 1;
        @(posedge clk);
      end
      check("stopped", c, 0);
    end
  endtask

  // Reset for 16 cycles, then run the scenarios in turn.
  initial begin
    rst_b        = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    num_errors   = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_timed;
    t_width;
    t_rate;
    t_soft;
    t_free;
    final_report;
  end
endmodule
